// File: rtl/pcit_cmd_decode.sv
// command decoder: sorts a c/be# command code into claimable classes
// assumes the code is sampled during the address phase only
`timescale 1ns/1ps
module pcit_cmd_decode (
  input  wire logic [3:0] cbe_n,
  output logic            cmd_ok,
  output logic            cmd_write,
  output logic            cmd_io,
  output logic            cmd_mem,
  output logic            cmd_cfg
);

  // aliases fold onto the plain read and write; all others stay unclaimed
  always_comb begin
    cmd_ok    = 1'b1;
    cmd_write = 1'b0;
    cmd_io    = 1'b0;
    cmd_mem   = 1'b0;
    cmd_cfg   = 1'b0;
    case (cbe_n)
      pcit_pkg::CMD_IO_RD: cmd_io = 1'b1;
      pcit_pkg::CMD_IO_WR: begin
        cmd_io    = 1'b1;
        cmd_write = 1'b1;
      end
      pcit_pkg::CMD_MEM_RD,
      pcit_pkg::CMD_MEM_RDM,
      pcit_pkg::CMD_MEM_RDL: cmd_mem = 1'b1;
      pcit_pkg::CMD_MEM_WR,
      pcit_pkg::CMD_MEM_WRI: begin
        cmd_mem   = 1'b1;
        cmd_write = 1'b1;
      end
      pcit_pkg::CMD_CFG_RD: cmd_cfg = 1'b1;
      pcit_pkg::CMD_CFG_WR: begin
        cmd_cfg   = 1'b1;
        cmd_write = 1'b1;
      end
      default: cmd_ok = 1'b0; // interrupt ack, special cycle, reserved
    endcase
  end

endmodule

// File: rtl/pcit_pkg.sv
// constants shared by the pci target interface and its helpers
// assumes the whole block runs on the pci clock
package pcit_pkg;

  localparam int AD_W  = 32;
  localparam int CBE_W = 4;
  localparam int LAT_W = 5;

  // bus command codes as seen on the c/be# pins during the address phase
  localparam logic [3:0] CMD_IO_RD    = 4'h2;
  localparam logic [3:0] CMD_IO_WR    = 4'h3;
  localparam logic [3:0] CMD_MEM_RD   = 4'h6;
  localparam logic [3:0] CMD_MEM_WR   = 4'h7;
  localparam logic [3:0] CMD_CFG_RD   = 4'ha;
  localparam logic [3:0] CMD_CFG_WR   = 4'hb;
  localparam logic [3:0] CMD_MEM_RDM  = 4'hc;
  localparam logic [3:0] CMD_MEM_RDL  = 4'he;
  localparam logic [3:0] CMD_MEM_WRI  = 4'hf;

  // address phase fields
  localparam logic [1:0] ORDER_LINEAR = 2'h0;
  localparam logic [1:0] CFG_TYPE0    = 2'h0;
  localparam logic [AD_W-1:0] ADDR_STEP = 32'h0000_0004;

  // latency limits, in pci clocks
  localparam logic [LAT_W-1:0] LAT_FIRST = 5'h10;
  localparam logic [LAT_W-1:0] LAT_LATER = 5'h08;

  // reset values of the pin drivers
  localparam logic [AD_W-1:0] AD_RST = 32'h0000_0000;

  // which internal path a claimed cycle goes to
  typedef enum logic [2:0] {
    SP_NONE,
    SP_OPREG,
    SP_CFG,
    SP_ROM,
    SP_WIN
  } pcit_space_e;

endpackage

// File: rtl/pcit_target.sv
// pci target interface: claims, sequences and terminates target cycles
// assumes every pci input is synchronous to mclk (the pci clock itself)
// assumes the hit inputs are decoded combinationally from ad_in
// Contract
// - claim only i/o, memory and configuration reads and writes, aliases included
// - memory read multiple and read line behave as a memory read
// - memory write and invalidate behaves as a memory write
// - latch address and command in the clock frame# first goes active
// - reads leave ad floating one clock after address; writes have none
// - frame# high marks last phase; a phase ends when irdy# and trdy# low
// - bus is idle once frame# and irdy# are both high
// - non-linear burst order: finish first phase with stop# asserted
// - register, configuration and rom bursts: one transfer with stop#
// - the four base address windows may burst over many phases
// - on reads trdy# stays high until valid data sits on ad
// - register read: stop# in clock three if frame# held with irdy#
// - pass-through read with empty buffer: stop# without trdy#, no data; here only at the latency limit, never with latency_en low
// - rom read retried until the serial memory fetch holds four bytes
// - register write: stop# in clock three, initiator may wait with irdy#
// - pass-through write bursts while room remains; full gives a retry
// - first pass-through read phase retried after sixteen clocks without data
// - retry is stop# and devsel# low with trdy# high
// - disconnect is stop#, trdy# and devsel# low together
// - never target abort: devsel# stays low whenever stop# is low
// - latency limits 16 then 8 clocks, ignored when latency_en is low
`timescale 1ns/1ps
module pcit_target #(
  parameter int AD_W = pcit_pkg::AD_W
) (
  input  wire logic            mclk,
  input  wire logic            rst_b,
  // pci bus side
  input  wire logic            frame_n,
  input  wire logic            irdy_n,
  input  wire logic            idsel,
  input  wire logic [3:0]      cbe_n,
  input  wire logic [AD_W-1:0] ad_in,
  output logic      [AD_W-1:0] ad_out,
  output logic                 ad_oe,
  output logic                 devsel_n,
  output logic                 devsel_oe,
  output logic                 trdy_n,
  output logic                 trdy_oe,
  output logic                 stop_n,
  output logic                 stop_oe,
  // address decode results for the current ad_in
  input  wire logic            opreg_hit,
  input  wire logic            rom_hit,
  input  wire logic            win_hit,
  // serial_config_memory byte 45h bit 0
  input  wire logic            latency_en,
  // internal read, write and rom paths
  input  wire logic            rd_valid,
  input  wire logic [AD_W-1:0] rd_data,
  input  wire logic            rom_ready,
  input  wire logic            wr_room,
  output logic                 acc_active,
  output logic                 acc_write,
  output logic      [2:0]      acc_space,
  output logic      [AD_W-1:0] acc_addr,
  output logic                 rd_pop,
  output logic                 wr_strobe,
  output logic      [AD_W-1:0] wr_data,
  output logic      [3:0]      wr_be
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DATA,
    ST_TERM,
    ST_RELEASE
  } pcit_state_e;

  pcit_state_e         state;
  pcit_pkg::pcit_space_e space;
  pcit_pkg::pcit_space_e hit_space;
  logic                bus_idle_q;
  logic                drive;
  logic                nonlin;
  logic                first;
  logic                cmd_ok;
  logic                cmd_write;
  logic                cmd_io;
  logic                cmd_mem;
  logic                cmd_cfg;
  logic                addr_phase;
  logic                claim;
  logic                single;
  logic                xfer;
  logic                room;
  logic                rd_ok;
  logic                ready;
  logic                refuse_now;
  logic                timeout;
  logic                lat_exp;
  logic                waiting;
  logic                cont;
  logic                load_rd;
  logic                stop_next;
  logic                abandon;
  logic                term_done;

  pcit_cmd_decode u_dec (
    .cbe_n     (cbe_n),
    .cmd_ok    (cmd_ok),
    .cmd_write (cmd_write),
    .cmd_io    (cmd_io),
    .cmd_mem   (cmd_mem),
    .cmd_cfg   (cmd_cfg)
  );

  // first-phase limit until a transfer completes, later-phase limit after
  pcit_wait_cnt #(
    .W (pcit_pkg::LAT_W)
  ) u_lat (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .clear   (claim || xfer),
    .run     (state == ST_DATA),
    .limit   (first ? pcit_pkg::LAT_FIRST : pcit_pkg::LAT_LATER),
    .expired (lat_exp)
  );

  // idle tracking: an address phase needs an idle bus the clock before
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bus_idle_q <= 1'b1;
    end else begin
      bus_idle_q <= frame_n && irdy_n;
    end
  end

  assign addr_phase = bus_idle_q && !frame_n && (state == ST_IDLE);

  // space select; configuration needs idsel and a type 0 address
  always_comb begin
    hit_space = pcit_pkg::SP_NONE;
    if (cmd_cfg && idsel && (ad_in[1:0] == pcit_pkg::CFG_TYPE0)) begin
      hit_space = pcit_pkg::SP_CFG;
    end else if ((cmd_io || cmd_mem) && opreg_hit) begin
      hit_space = pcit_pkg::SP_OPREG;
    end else if (cmd_mem && rom_hit) begin
      hit_space = pcit_pkg::SP_ROM;
    end else if ((cmd_io || cmd_mem) && win_hit) begin
      hit_space = pcit_pkg::SP_WIN;
    end
  end

  // a miss leaves devsel# undriven, so the initiator master-aborts
  assign claim = addr_phase && cmd_ok && (hit_space != pcit_pkg::SP_NONE);

  // data phase decisions, all made one clock ahead of the pins
  always_comb begin
    single     = (space != pcit_pkg::SP_WIN) || nonlin;
    xfer       = !irdy_n && !trdy_n && drive;
    room       = (space == pcit_pkg::SP_WIN) ? wr_room : 1'b1;
    rd_ok      = rd_valid && ((space != pcit_pkg::SP_ROM) || rom_ready);
    ready      = acc_write ? room : rd_ok;
    refuse_now = acc_write ? !room
                           : ((space == pcit_pkg::SP_ROM) && !rom_ready && first);
    timeout    = latency_en && lat_exp;
    waiting    = (state == ST_DATA) && trdy_n && stop_n;
    cont       = (state == ST_DATA) && xfer && !frame_n && stop_n && !single;
    load_rd    = !acc_write && rd_ok && (waiting || cont);
    // writes to single-phase spaces always stop; reads only on a burst
    // frame# alone is only initiator waiting, a burst needs irdy# with it
    stop_next  = single && (acc_write || (!frame_n && !irdy_n));
    // initiator gave up on its own with both handshakes released
    abandon    = (state == ST_DATA) && frame_n && irdy_n;
    term_done  = frame_n && (trdy_n || !irdy_n);
  end

  assign rd_pop = load_rd;

  // cycle sequencer
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (claim) begin
            state <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (abandon) begin
            state <= ST_RELEASE;
          end else if (waiting && ready && stop_next) begin
            state <= ST_TERM;
          end else if (waiting && !ready && (refuse_now || timeout)) begin
            state <= ST_TERM;
          end else if (xfer && frame_n) begin
            state <= ST_RELEASE;
          end else if (xfer && single) begin
            state <= ST_TERM;
          end
        end
        ST_TERM: begin
          if (term_done) begin
            state <= ST_RELEASE;
          end
        end
        ST_RELEASE: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // target control pins; all three are driven high for one clock before float
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      drive    <= 1'b0;
      devsel_n <= 1'b1;
      trdy_n   <= 1'b1;
      stop_n   <= 1'b1;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (claim) begin
            drive    <= 1'b1;
            devsel_n <= 1'b0;
          end
        end
        ST_DATA: begin
          if (abandon) begin
            devsel_n <= 1'b1;
            trdy_n   <= 1'b1;
          end else if (waiting && ready) begin
            trdy_n <= 1'b0;
            stop_n <= !stop_next;
          end else if (waiting && (refuse_now || timeout)) begin
            stop_n <= 1'b0;
          end else if (xfer && frame_n) begin
            trdy_n   <= 1'b1;
            devsel_n <= 1'b1;
          end else if (xfer && single) begin
            trdy_n <= 1'b1;
            stop_n <= 1'b0;
          end else if (cont) begin
            trdy_n <= !ready;
          end
        end
        ST_TERM: begin
          // devsel# held low through stop#, so no abort is ever shown
          if (term_done) begin
            stop_n   <= 1'b1;
            trdy_n   <= 1'b1;
            devsel_n <= 1'b1;
          end else if (xfer) begin
            trdy_n <= 1'b1;
          end
        end
        ST_RELEASE: begin
          drive <= 1'b0;
        end
      endcase
    end
  end

  assign devsel_oe = drive;
  assign trdy_oe   = drive;
  assign stop_oe   = drive;

  // ad drive: set at the end of the turn-around clock, so never in it
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ad_oe <= 1'b0;
    end else if (((state == ST_DATA) && !acc_write && !abandon && !(xfer && frame_n)) ||
                 ((state == ST_TERM) && !acc_write && !trdy_n && !term_done && !xfer)) begin
      ad_oe <= 1'b1;
    end else begin
      ad_oe <= 1'b0;
    end
  end

  // read data register; a word is fetched ahead only while frame# shows the burst goes on
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ad_out <= pcit_pkg::AD_RST;
    end else if (load_rd) begin
      ad_out <= rd_data;
    end
  end

  // cycle attributes latched in the address phase
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      space     <= pcit_pkg::SP_NONE;
      acc_write <= 1'b0;
      nonlin    <= 1'b0;
    end else if (claim) begin
      space     <= hit_space;
      acc_write <= cmd_write;
      nonlin    <= cmd_mem && (ad_in[1:0] != pcit_pkg::ORDER_LINEAR);
    end
  end

  // address counter steps one doubleword per completed phase
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      acc_addr <= pcit_pkg::AD_RST;
    end else if (claim) begin
      acc_addr <= ad_in;
    end else if (xfer) begin
      acc_addr <= acc_addr + pcit_pkg::ADDR_STEP;
    end
  end

  // first-phase flag picks the latency limit
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      first <= 1'b1;
    end else if (claim) begin
      first <= 1'b1;
    end else if (xfer) begin
      first <= 1'b0;
    end
  end

  // write data handed on one clock after the phase completes
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_strobe <= 1'b0;
      wr_data   <= pcit_pkg::AD_RST;
      wr_be     <= 4'h0;
    end else begin
      wr_strobe <= xfer && acc_write;
      if (xfer && acc_write) begin
        wr_data <= ad_in;
        wr_be   <= ~cbe_n;
      end
    end
  end

  assign acc_active = (state != ST_IDLE);
  assign acc_space  = space;

endmodule

// File: rtl/pcit_wait_cnt.sv
// wait counter: counts clocks since the last clear, flags the limit
// assumes clear marks a clock that itself counts as the first
`timescale 1ns/1ps
module pcit_wait_cnt #(
  parameter int W = 5
) (
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic         clear,
  input  wire logic         run,
  input  wire logic [W-1:0] limit,
  output logic              expired
);

  logic [W-1:0] cnt;

  // saturates so a long wait with the limit ignored cannot wrap
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= '0;
    end else if (clear) begin
      cnt <= {{(W-1){1'b0}}, 1'b1};
    end else if (run && (cnt != {W{1'b1}})) begin
      cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
    end
  end

  // expires in the clock whose decision shows on the pins limit clocks after clear
  assign expired = run && (cnt >= (limit - {{(W-1){1'b0}}, 1'b1}));

endmodule

// File: verif/pcit_initiator.sv
// initiator model: runs one pci transaction at a time against the target
// assumes target outputs arrive already resolved through their pull-ups
`timescale 1ns/1ps
module pcit_initiator (
  input  wire logic        mclk,
  input  wire logic        devsel_n,
  input  wire logic        trdy_n,
  input  wire logic        stop_n,
  input  wire logic [31:0] ad_out,
  output logic             frame_n,
  output logic             irdy_n,
  output logic      [3:0]  cbe_n,
  output logic      [31:0] ad
);
  // bus idle at time zero
  initial begin
    frame_n = 1'b1;
    irdy_n  = 1'b1;
    cbe_n   = 4'hf;
    ad      = 32'h0000_0000;
  end

  // n phases wanted, ws wait clocks before the first irdy
  task automatic run(input logic [3:0] cmd, input logic [31:0] addr, input int n, input int ws,
                     output logic [31:0] rdat, output int nx, output logic stp);
    logic x;
    int   k;
    nx   = 0;
    stp  = 1'b0;
    rdat = 32'h0000_0000;
    @(posedge mclk);
    frame_n <= 1'b0;
    cbe_n   <= cmd;
    ad      <= addr;
    for (k = 0; k < 40; k++) begin
      @(posedge mclk);
      x = !irdy_n && !trdy_n;
      if (x) begin
        nx++;
        rdat = ad_out;
      end
      if (!stop_n) stp = 1'b1;
      if (frame_n && (x || !stop_n || devsel_n)) break;
      irdy_n  <= (k < ws);
      // frame only rises while irdy is low
      frame_n <= (k >= ws) && (n - nx <= 1 || stp || (k > 3 && devsel_n));
      cbe_n   <= 4'h0;
      ad      <= cmd[0] ? 32'ha5a5_0000 + 32'(nx) : ~ad;
    end
    // bound used up: an impossible count makes the caller's check fail
    if (k == 40) nx = -1;
    frame_n <= 1'b1;
    irdy_n  <= 1'b1;
    ad      <= ~ad; // released lines never keep their last value
  endtask
endmodule

// File: verif/pcit_target_monitor.sv
// checker: timing relations between the target pins and its back side
// assumes it is bound to pcit_target and that everything runs on mclk
`timescale 1ns/1ps
module pcit_target_monitor (
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire logic       frame_n,
  input wire logic       irdy_n,
  input wire logic       idsel,
  input wire logic [3:0] cbe_n,
  input wire logic       opreg_hit,
  input wire logic       rom_hit,
  input wire logic       win_hit,
  input wire logic       latency_en,
  input wire logic       rd_valid,
  input wire logic       rom_ready,
  input wire logic       wr_room,
  input wire logic       ad_oe,
  input wire logic       devsel_n,
  input wire logic       trdy_n,
  input wire logic       stop_n,
  input wire logic       acc_write,
  input wire logic       wr_strobe
);
  logic       idle_q;
  logic       first_q;
  logic [4:0] wait_q;
  wire        addr_ph = !frame_n && idle_q;
  wire        rd_cmd  = !cbe_n[0];
  wire        sup     = cbe_n inside {4'h2, 4'h3, 4'h6, 4'h7, 4'ha, 4'hb, 4'hc, 4'he, 4'hf};

  // idle tracking plus claimed clocks with trdy# high, saturating
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      idle_q  <= 1'b1;
      first_q <= 1'b0;
      wait_q  <= 5'h00;
    end else begin
      idle_q  <= frame_n && irdy_n;
      first_q <= addr_ph ? 1'b1 : (!trdy_n ? 1'b0 : first_q);
      wait_q  <= (devsel_n || !trdy_n) ? 5'h00 : wait_q + {4'h0, wait_q != 5'h1f};
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_opreg_rd;
    addr_ph && sup && rd_cmd && opreg_hit;
  endsequence
  sequence s_opreg_wr;
    addr_ph && sup && !rd_cmd && opreg_hit;
  endsequence
  sequence s_win_wr;
    addr_ph && sup && !rd_cmd && win_hit && !opreg_hit && !rom_hit;
  endsequence
  sequence s_rom_rd;
    addr_ph && sup && rd_cmd && rom_hit && !opreg_hit;
  endsequence

  a_no_abort: assert property (!stop_n |-> !devsel_n)
    else $error("stop driven without devsel");
  a_bad_cmd_ignored: assert property (addr_ph && !sup |=> devsel_n [*2])
    else $error("unsupported command claimed");
  a_claim_fast: assert property (addr_ph && sup && opreg_hit && idsel |=> !devsel_n)
    else $error("supported command not claimed");
  a_read_turn: assert property (addr_ph && sup && rd_cmd |=> !ad_oe)
    else $error("ad driven in turn-around clock");
  a_read_data: assert property (!trdy_n && !acc_write |-> ad_oe)
    else $error("read ready without data on ad");
  a_opreg_rd_stop: assert property (s_opreg_rd ##1 (!frame_n && !irdy_n && rd_valid)
    |=> !stop_n && !trdy_n)
    else $error("register read burst not disconnected");
  a_opreg_wr_stop: assert property (s_opreg_wr |-> ##2 (!stop_n && !trdy_n))
    else $error("register write not disconnected in clock three");
  a_wr_full_retry: assert property (s_win_wr ##1 !wr_room |=> !stop_n && trdy_n)
    else $error("full write buffer not retried");
  a_rom_retry: assert property (s_rom_rd ##1 !rom_ready |=> !stop_n && trdy_n)
    else $error("rom read not retried");
  a_first_latency: assert property (latency_en && first_q && wait_q == 5'h0f
    |-> !stop_n && trdy_n)
    else $error("first phase limit missed");
  a_latency_off: assert property (!latency_en && wait_q == 5'h13 |-> stop_n)
    else $error("stop issued with latency limits off");
  a_wr_strobe: assert property (!trdy_n && !irdy_n && acc_write |=> wr_strobe)
    else $error("write phase without strobe");
endmodule

bind pcit_target pcit_target_monitor pcit_target_monitor_inst (
  .mclk(mclk), .rst_b(rst_b), .frame_n(frame_n), .irdy_n(irdy_n), .idsel(idsel),
  .cbe_n(cbe_n), .opreg_hit(opreg_hit), .rom_hit(rom_hit), .win_hit(win_hit),
  .latency_en(latency_en), .rd_valid(rd_valid), .rom_ready(rom_ready), .wr_room(wr_room),
  .ad_oe(ad_oe), .devsel_n(devsel_n), .trdy_n(trdy_n), .stop_n(stop_n),
  .acc_write(acc_write), .wr_strobe(wr_strobe)
);

// File: verif/tb_pci_target_interface.sv
// testbench: pci target against the initiator model, back side driven here
// assumes regions by ad bits 31:28: 4 registers and config, 2 rom, 3 window
`timescale 1ns/1ps
module tb_pci_target_interface;
  logic        mclk, rst_b, latency_en, rd_valid, rom_ready, wr_room;
  logic        frame_n, irdy_n, ad_oe, devsel_n, devsel_oe, trdy_n, trdy_oe, stop_n, stop_oe;
  logic        wr_strobe;
  logic [3:0]  cbe_n, wr_be, be_last;
  logic [31:0] ad_i, ad_in, ad_out, rd_data, wr_data, wr_last;
  int          error_cnt, comparisons, wr_cnt;
  wire         dev_w  = devsel_oe ? devsel_n : 1'b1;
  wire         trdy_w = trdy_oe ? trdy_n : 1'b1;
  wire         stop_w = stop_oe ? stop_n : 1'b1;

  // address decode and shared ad wire
  assign ad_in = ad_oe ? ad_out : ad_i;

  pcit_target pcit_target_inst (
    .mclk(mclk), .rst_b(rst_b), .frame_n(frame_n), .irdy_n(irdy_n),
    .idsel(ad_in[31:28] == 4'h4), .cbe_n(cbe_n), .ad_in(ad_in), .ad_out(ad_out),
    .ad_oe(ad_oe), .devsel_n(devsel_n), .devsel_oe(devsel_oe), .trdy_n(trdy_n),
    .trdy_oe(trdy_oe), .stop_n(stop_n), .stop_oe(stop_oe),
    .opreg_hit(ad_in[31:28] == 4'h4), .rom_hit(ad_in[31:28] == 4'h2),
    .win_hit(ad_in[31:28] == 4'h3), .latency_en(latency_en), .rd_valid(rd_valid),
    .rd_data(rd_data), .rom_ready(rom_ready), .wr_room(wr_room), .acc_active(),
    .acc_write(), .acc_space(), .acc_addr(), .rd_pop(), .wr_strobe(wr_strobe),
    .wr_data(wr_data), .wr_be(wr_be)
  );

  pcit_initiator pcit_initiator_inst (
    .mclk(mclk), .devsel_n(dev_w), .trdy_n(trdy_w), .stop_n(stop_w), .ad_out(ad_in),
    .frame_n(frame_n), .irdy_n(irdy_n), .cbe_n(cbe_n), .ad(ad_i)
  );

  // back-side write capture
  always @(posedge mclk) begin
    if (wr_strobe === 1'b1) begin
      wr_cnt++;
      wr_last = wr_data;
      be_last = wr_be;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic xact(input logic [3:0] cmd, input logic [31:0] addr, input int n, input int ws,
                      input int enx, input logic estp);
    logic [31:0] rdat;
    int          nx;
    logic        stp;
    pcit_initiator_inst.run(cmd, addr, n, ws, rdat, nx, stp);
    check("transfers", 32'(nx), 32'(enx));
    check("stop seen", {31'h0, stp}, {31'h0, estp});
    if (nx > 0 && !cmd[0]) check("read data", rdat, rd_data);
  endtask

  // every code once; register writes always disconnect
  task automatic t_cmds();
    for (int c = 0; c < 16; c++)
      xact(4'(c), 32'h4000_0000, 1, 0, (c inside {2, 3, 6, 7, 10, 11, 12, 14, 15}),
           (c inside {3, 7, 11, 15}));
  endtask

  // bursts cut after one phase, except an i/o read burst to the window; irdy waits alone are no burst
  task automatic t_cut();
    xact(4'h6, 32'h4000_0000, 4, 0, 1, 1'b1);
    xact(4'h6, 32'h4000_0000, 1, 1, 1, 1'b0);
    xact(4'h6, 32'h4000_0000, 4, 1, 1, 1'b1);
    xact(4'h7, 32'h4000_0000, 4, 2, 1, 1'b1);
    xact(4'hc, 32'h3000_0002, 4, 0, 1, 1'b1);
    xact(4'h2, 32'h3000_0000, 3, 1, 3, 1'b0);
  endtask

  // window write bursts, then a full buffer
  task automatic t_win_wr();
    wr_cnt = 0;
    xact(4'h7, 32'h3000_0000, 4, 0, 4, 1'b0);
    xact(4'hf, 32'h3000_0010, 4, 0, 4, 1'b0);
    repeat (3) @(posedge mclk);
    check("strobes", 32'(wr_cnt), 32'h8);
    check("last word", wr_last, 32'ha5a5_0003);
    check("byte lanes", {28'h0, be_last}, 32'hf);
    wr_room <= 1'b0;
    xact(4'h7, 32'h3000_0000, 2, 0, 0, 1'b1);
    wr_room <= 1'b1;
  endtask

  // slow back side with limits on, then with limits off
  task automatic t_latency();
    rd_valid <= 1'b0;
    xact(4'he, 32'h3000_0000, 1, 0, 0, 1'b1);
    latency_en <= 1'b0;
    fork
      xact(4'h6, 32'h3000_0000, 1, 0, 1, 1'b0);
      begin
        repeat (25) @(posedge mclk);
        rd_valid <= 1'b1;
      end
    join
    latency_en <= 1'b1;
  endtask

  // rom fetch unfinished, then a rom burst attempt
  task automatic t_rom();
    rom_ready <= 1'b0;
    xact(4'h6, 32'h2000_0000, 1, 0, 0, 1'b1);
    rom_ready <= 1'b1;
    xact(4'h6, 32'h2000_0004, 2, 0, 1, 1'b1);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // reset, then the scenarios in turn
  initial begin
    rst_b      = 1'b0;
    latency_en = 1'b1;
    rd_valid   = 1'b1;
    rom_ready  = 1'b1;
    wr_room    = 1'b1;
    rd_data    = 32'hc0de_5a01;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    t_cmds();
    t_cut();
    t_win_wr();
    t_latency();
    t_rom();
    tally_and_finish();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    tally_and_finish();
  end
endmodule
